// file: logic/fault_status_pkg.sv
/*
  Constants and carrier types for the fault status summary bank: command
  codes, field positions of each status byte, channel counts.
  Assumes the management-bus command layer decodes frames and hands reads to
  the bank as command codes on the system clock.
*/
`default_nettype none

package fault_status_pkg;

  // Channel counts
  localparam int unsigned NUM_OUT = 2;

  // Command codes of the four status registers
  localparam logic [7:0] CMD_SUM_BYTE = 8'h78;
  localparam logic [7:0] CMD_SUM_WORD = 8'h79;
  localparam logic [7:0] CMD_VOUT_DET = 8'h7a;
  localparam logic [7:0] CMD_OUT_CURRENT_SUMMARY_FLAG_DET = 8'h7b;

  // Read data reset value
  localparam logic [15:0] RD_DATA_RST = 16'h0000;

  // Summary byte fields
  localparam int unsigned SB_UNUSED  = 7;
  localparam int unsigned SB_OFF     = 6;
  localparam int unsigned SB_VOUT_OV = 5;
  localparam int unsigned SB_OUT_CURRENT_SUMMARY_FLAG_OC = 4;
  localparam int unsigned SB_VIN_UV  = 3;
  localparam int unsigned SB_TEMP    = 2;
  localparam int unsigned SB_CML     = 1;
  localparam int unsigned SB_OTHER   = 0;

  // Summary word high fields
  localparam int unsigned SW_VOUT  = 15;
  localparam int unsigned SW_OUT_CURRENT_SUMMARY_FLAG  = 14;
  localparam int unsigned SW_INPUT = 13;
  localparam int unsigned SW_MFR   = 12;
  localparam int unsigned SW_PG_N  = 11;

  // Output voltage detail fields
  localparam int unsigned VD_OV   = 7;
  localparam int unsigned VD_UV   = 4;
  localparam int unsigned VD_VMAX = 3;

  // Output current detail fields
  localparam int unsigned ID_OC    = 7;
  localparam int unsigned ID_OC_UV = 6;
  localparam int unsigned ID_SHARE = 3;

  // Global detail fields feeding the summaries
  localparam int unsigned IN_OV = 7;
  localparam int unsigned IN_UV = 4;
  localparam int unsigned IN_OC = 2;
  localparam int unsigned TP_OT  = 7;
  localparam int unsigned TP_OTW = 6;
  localparam int unsigned TP_UT  = 4;
  localparam int unsigned CM_BAD_CMD   = 7;
  localparam int unsigned CM_BAD_DATA  = 6;
  localparam int unsigned CM_PEC_ERR   = 5;
  localparam int unsigned CM_MEM_FLT   = 4;
  localparam int unsigned CM_PROC_FLT  = 3;
  localparam int unsigned CM_OTHER_COM = 1;
  localparam int unsigned CM_OTHER_MEM = 0;
  localparam int unsigned MF_OTP_FULL  = 1;

  // Per-output fault comparator levels
  typedef struct packed {
    logic ov;
    logic uv;
    logic vmax;
    logic oc;
    logic oc_uv;
    logic share;
  } out_faults_t;

  // Global fault comparator levels
  typedef struct packed {
    logic in_ov;
    logic in_uv;
    logic in_oc;
    logic ot;
    logic otw;
    logic ut;
    logic otp_full;
  } glob_faults_t;

  // Communication, memory and logic events from on-chip logic
  typedef struct packed {
    logic bad_cmd;
    logic bad_data;
    logic pec_err;
    logic mem_flt;
    logic proc_flt;
    logic other_com;
    logic other_mem;
  } cml_evt_t;

  localparam int unsigned OUT_W  = $bits(out_faults_t);
  localparam int unsigned GLOB_W = $bits(glob_faults_t);
  localparam int unsigned CML_W  = $bits(cml_evt_t);
  localparam int unsigned FLAG_W = NUM_OUT * OUT_W + GLOB_W + CML_W;

endpackage

`default_nettype wire

// file: logic/level_sync.sv
/*
  Two-flop synchroniser for a vector of independent levels.
  Assumes each bit is a slow level; no bus coherence between bits.
*/
`default_nettype none

module level_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  // Levels
  input  wire logic [W-1:0] lvl_in,
  output logic      [W-1:0] lvl_out
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q  <= '0;
      lvl_out <= '0;
    end else begin
      meta_q  <= lvl_in;
      lvl_out <= meta_q;
    end
  end

endmodule

`default_nettype wire

// file: logic/sticky_flags.sv
/*
  Bank of sticky fault flags: a set level latches a flag, a clear pulse
  drops it. A set in the clear cycle wins, so no event is lost.
  Assumes set and clear come from the system clock domain.
*/
`default_nettype none

module sticky_flags #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  // Control
  input  wire logic [W-1:0] set_in,
  input  wire logic         clr,
  // Flags
  output logic      [W-1:0] flags_q
);

  logic [W-1:0] flags_d;

  // Set wins over clear
  assign flags_d = set_in | (flags_q & ~{W{clr}});

  // Flag storage
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end

endmodule

`default_nettype wire

// file: logic/fault_status_regs.sv
/*
  Fault status summary bank: global summary byte and word, paged output
  voltage and current detail bytes, answered by management-bus command code.
  Assumes the command layer issues one-cycle read and write requests on
  clk_sys and holds the selected page; fault pins are asynchronous levels.
*/
// Operation
// - Summary bit 6 set whenever any output delivers no power.
// - Summary bit 5 set after an output overvoltage fault.
// - Summary bit 4 set after an output overcurrent fault.
// - Summary bit 3 set after an input undervoltage fault.
// - Summary bit 2 set after a temperature fault or warning.
// - Summary bit 1 set after a communication, memory or logic fault.
// - Summary bit 0 flags other status changes; bit 7 reads zero.
// - Summary byte and word are global, covering both outputs.
// - Word low byte always equals the summary byte.
// - Word bit 15 set on any output voltage fault.
// - Word bit 14 set on any output current fault.
// - Word bit 13 set on any input fault.
// - Word bit 12 set on a vendor-specific event.
// - Word bit 11 set while power good is low; bits 10:7 zero.
// - Voltage detail bit 7 is overvoltage; bits 6:5 and 2:0 zero.
// - Voltage detail bit 4 is undervoltage.
// - Voltage detail bit 3 is maximum voltage warning.
// - Current detail bit 7 overcurrent, bit 6 overcurrent-undervoltage; 5:4 zero.
// - Current detail bit 3 is share fault; bits 2:0 zero.
// - Detail bytes are paged: they report the selected output.
// - Vendor detail bit 1 flags full one-time memory, feeding bit 12.
// - Communication detail bit 7 flags an invalid command, feeding bit 1.
`default_nettype none

module fault_status_regs
  import fault_status_pkg::*;
(
  // Clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       sys_rst,
  // Asynchronous fault and power pins
  input  wire out_faults_t [NUM_OUT-1:0]  out_flt_pin,
  input  wire logic        [NUM_OUT-1:0]  out_on_pin,
  input  wire logic        [NUM_OUT-1:0]  pgood_pin,
  input  wire glob_faults_t               glob_flt_pin,
  // On-chip events
  input  wire cml_evt_t                   cml_evt,
  input  wire logic                       clear_faults,
  // Command port
  input  wire logic                       page_sel,
  input  wire logic                       rd_req,
  input  wire logic                       wr_req,
  input  wire logic        [7:0]          cmd_code,
  output logic                            rd_valid_q,
  output logic                            rd_hit_q,
  output logic             [15:0]         rd_data_q
);

  localparam int unsigned PIN_W = NUM_OUT * (OUT_W + 2) + GLOB_W;

  logic [PIN_W-1:0]       pins_s;
  out_faults_t [NUM_OUT-1:0] out_s;
  logic [NUM_OUT-1:0]     on_s;
  logic [NUM_OUT-1:0]     pg_s;
  glob_faults_t           glob_s;
  logic [FLAG_W-1:0]      flags_q;
  out_faults_t [NUM_OUT-1:0] out_f;
  glob_faults_t           glob_f;
  cml_evt_t               cml_f;
  logic [NUM_OUT-1:0][7:0] vout_det;
  logic [NUM_OUT-1:0][7:0] out_current_summary_flag_det;
  logic [7:0]             input_det;
  logic [7:0]             temp_det;
  logic [7:0]             cml_det;
  logic [7:0]             mfr_det;
  logic [7:0]             sum_byte;
  logic [15:0]            sum_word;
  logic [15:0]            rd_data_d;
  logic                   rd_hit_d;
  logic                   all_on;
  logic                   all_pg;
  logic                   ov_any;
  logic                   oc_any;

  // Pins pass two flops before any logic reads them
  level_sync #(.W(PIN_W)) u_pin_sync (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .lvl_in  ({out_flt_pin, out_on_pin, pgood_pin, glob_flt_pin}),
    .lvl_out (pins_s)
  );
  assign {out_s, on_s, pg_s, glob_s} = pins_s;

  sticky_flags #(.W(FLAG_W)) u_flags (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .set_in  ({out_s, glob_s, cml_evt}),
    .clr     (clear_faults),
    .flags_q (flags_q)
  );
  assign {out_f, glob_f, cml_f} = flags_q;

  // paged detail bytes, unused bits zero
  for (genvar p = 0; p < NUM_OUT; p++) begin : g_out
    always_comb begin
      vout_det[p]           = 8'h00;
      vout_det[p][VD_OV]    = out_f[p].ov;
      vout_det[p][VD_UV]    = out_f[p].uv;
      vout_det[p][VD_VMAX]  = out_f[p].vmax;
      out_current_summary_flag_det[p]           = 8'h00;
      out_current_summary_flag_det[p][ID_OC]    = out_f[p].oc;
      out_current_summary_flag_det[p][ID_OC_UV] = out_f[p].oc_uv;
      out_current_summary_flag_det[p][ID_SHARE] = out_f[p].share;
    end
  end

  // Global detail bytes that the summaries aggregate
  always_comb begin
    input_det                = 8'h00;
    input_det[IN_OV]         = glob_f.in_ov;
    input_det[IN_UV]         = glob_f.in_uv;
    input_det[IN_OC]         = glob_f.in_oc;
    temp_det                 = 8'h00;
    temp_det[TP_OT]          = glob_f.ot;
    temp_det[TP_OTW]         = glob_f.otw;
    temp_det[TP_UT]          = glob_f.ut;
    cml_det                  = 8'h00;
    cml_det[CM_BAD_CMD]      = cml_f.bad_cmd;
    cml_det[CM_BAD_DATA]     = cml_f.bad_data;
    cml_det[CM_PEC_ERR]      = cml_f.pec_err;
    cml_det[CM_MEM_FLT]      = cml_f.mem_flt;
    cml_det[CM_PROC_FLT]     = cml_f.proc_flt;
    cml_det[CM_OTHER_COM]    = cml_f.other_com;
    cml_det[CM_OTHER_MEM]    = cml_f.other_mem;
    mfr_det                  = 8'h00;
    mfr_det[MF_OTP_FULL]     = glob_f.otp_full;
  end

  // both outputs reduced into global terms
  assign all_on = &on_s;
  assign all_pg = &pg_s;
  assign ov_any = |(vout_det[0][VD_OV] | vout_det[1][VD_OV]);
  assign oc_any = |(out_current_summary_flag_det[0][ID_OC] | out_current_summary_flag_det[1][ID_OC]);

  // bits 5:0 are ORs of detail flags; bit 6 follows the live output enables
  always_comb begin
    sum_byte             = 8'h00;
    sum_byte[SB_UNUSED]  = 1'b0;
    sum_byte[SB_OFF]     = ~all_on;
    sum_byte[SB_VOUT_OV] = ov_any;
    sum_byte[SB_OUT_CURRENT_SUMMARY_FLAG_OC] = oc_any;
    sum_byte[SB_VIN_UV]  = input_det[IN_UV];
    sum_byte[SB_TEMP]    = |temp_det;
    sum_byte[SB_CML]     = |cml_det;
    sum_byte[SB_OTHER]   = input_det[IN_OV] | input_det[IN_OC] | (|mfr_det)
                         | vout_det[0][VD_UV] | vout_det[1][VD_UV]
                         | vout_det[0][VD_VMAX] | vout_det[1][VD_VMAX]
                         | out_current_summary_flag_det[0][ID_OC_UV] | out_current_summary_flag_det[1][ID_OC_UV]
                         | out_current_summary_flag_det[0][ID_SHARE] | out_current_summary_flag_det[1][ID_SHARE];
  end

  // low byte is the summary byte; bits 10:7 zero
  always_comb begin
    sum_word           = {8'h00, sum_byte};
    sum_word[SW_VOUT]  = |(vout_det[0] | vout_det[1]);
    sum_word[SW_OUT_CURRENT_SUMMARY_FLAG]  = |(out_current_summary_flag_det[0] | out_current_summary_flag_det[1]);
    sum_word[SW_INPUT] = |input_det;
    sum_word[SW_MFR]   = |mfr_det;
    sum_word[SW_PG_N]  = ~all_pg;
  end

  // read mux by command code, detail bytes by page
  always_comb begin
    rd_data_d = RD_DATA_RST;
    rd_hit_d  = 1'b1;
    case (cmd_code)
      CMD_SUM_BYTE: rd_data_d = {8'h00, sum_byte};
      CMD_SUM_WORD: rd_data_d = sum_word;
      CMD_VOUT_DET: rd_data_d = {8'h00, vout_det[page_sel]};
      CMD_OUT_CURRENT_SUMMARY_FLAG_DET: rd_data_d = {8'h00, out_current_summary_flag_det[page_sel]};
      default:      rd_hit_d  = 1'b0;
    endcase
  end

  // read answer; writes reach no storage here
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rd_valid_q <= 1'b0;
      rd_hit_q   <= 1'b0;
      rd_data_q  <= RD_DATA_RST;
    end else begin
      rd_valid_q <= rd_req;
      if (rd_req) begin
        rd_hit_q  <= rd_hit_d;
        rd_data_q <= rd_data_d;
      end
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_read(logic [7:0] code);
    rd_req && !wr_req && cmd_code == code;
  endsequence

  sequence s_answer;
    rd_valid_q && rd_hit_q;
  endsequence

  a_off_bit: assert property (
    s_read(CMD_SUM_BYTE) |=> s_answer ##0 rd_data_q[SB_OFF] == !$past(all_on))
    else $error("off bit does not follow output enables");

  a_fault_bits: assert property (
    s_read(CMD_SUM_BYTE) |=> rd_data_q[SB_VOUT_OV] == $past(ov_any)
      && rd_data_q[SB_OUT_CURRENT_SUMMARY_FLAG_OC] == $past(oc_any))
    else $error("overvoltage or overcurrent summary bit wrong");

  a_byte_upper_zero: assert property (
    s_read(CMD_SUM_BYTE) |=> rd_data_q[15:SB_UNUSED] == 9'h000)
    else $error("summary byte unused bits not zero");

  a_word_low_same: assert property (
    s_read(CMD_SUM_WORD) |=> rd_data_q[7:0] == $past(sum_byte))
    else $error("word low byte differs from summary byte");

  a_word_pg_bit: assert property (
    s_read(CMD_SUM_WORD) |=> rd_data_q[SW_PG_N] == !$past(all_pg)
      && rd_data_q[10:7] == 4'h0)
    else $error("power good bit or unused word bits wrong");

  a_temp_bit: assert property (
    s_read(CMD_SUM_BYTE) ##0 (glob_f.ot || glob_f.otw || glob_f.ut) |=> rd_data_q[SB_TEMP])
    else $error("temperature summary bit missing");

  a_input_word: assert property (
    s_read(CMD_SUM_WORD) ##0 (glob_f.in_ov || glob_f.in_uv || glob_f.in_oc)
      |=> rd_data_q[SW_INPUT])
    else $error("input summary bit missing in word");

  a_vout_word: assert property (
    s_read(CMD_SUM_WORD) ##0 ov_any |=> rd_data_q[SW_VOUT])
    else $error("output voltage bit missing in word");

  a_vout_unused: assert property (
    s_read(CMD_VOUT_DET) |=> (rd_data_q & 16'hff67) == 16'h0000)
    else $error("voltage detail unused bits set");

  a_out_current_summary_flag_unused: assert property (
    s_read(CMD_OUT_CURRENT_SUMMARY_FLAG_DET) |=> (rd_data_q & 16'hff37) == 16'h0000)
    else $error("current detail unused bits set");

  a_paged_ov: assert property (
    s_read(CMD_VOUT_DET) ##0 out_f[1].ov && !out_f[0].ov && page_sel
      |=> rd_data_q[VD_OV])
    else $error("voltage detail ignores selected page");

  a_bad_cmd_sticks: assert property (
    cml_evt.bad_cmd |=> cml_f.bad_cmd)
    else $error("invalid command flag not latched");

  a_bad_cmd_sum: assert property (
    s_read(CMD_SUM_BYTE) ##0 cml_f.bad_cmd |=> rd_data_q[SB_CML])
    else $error("invalid command does not reach summary");

  a_otp_to_word: assert property (
    s_read(CMD_SUM_WORD) ##0 glob_f.otp_full |=> rd_data_q[SW_MFR])
    else $error("full memory flag not in word");

  a_write_no_change: assert property (
    wr_req && !rd_req |=> $stable(rd_data_q) && !rd_valid_q)
    else $error("write disturbed read data");

endmodule

`default_nettype wire

// file: testbench/status_poller.sv
/*
  Host-side poller model: issues one-cycle read or write requests on the
  command port of the fault status bank.
  Assumes requests are changed at the falling edge of clk_sys.
*/
`default_nettype none

module status_poller (
  // Clock
  input  wire logic       clk_sys,
  // Command port toward the bank
  output logic            rd_req,
  output logic            wr_req,
  output logic      [7:0] cmd_code,
  output logic            page_sel
);
  timeunit 1ns;
  timeprecision 1ps;

  // Quiet command port at time zero
  initial begin
    rd_req   = 1'b0;
    wr_req   = 1'b0;
    cmd_code = 8'h00;
    page_sel = 1'b0;
  end

  // One request, held for exactly one rising edge
  task automatic issue(input logic wr, input logic [7:0] code, input logic pg);
    @(negedge clk_sys);
    rd_req   = ~wr;
    wr_req   = wr;
    cmd_code = code;
    page_sel = pg;
  endtask

  // Request lines drop; code and page lines show the inverse of their last value
  task automatic idle();
    @(negedge clk_sys);
    rd_req   = 1'b0;
    wr_req   = 1'b0;
    cmd_code = ~cmd_code;
    page_sel = ~page_sel;
  endtask

  task automatic poll(input logic pg);
    issue(1'b0, 8'h78, pg);
    issue(1'b0, 8'h79, pg);
    issue(1'b0, 8'h7a, pg);
    issue(1'b0, 8'h7b, pg);
  endtask
endmodule

`default_nettype wire

// file: testbench/fault_status_summary_regs_tb.sv
/*
  Self-checking bench for the fault status bank: one-hot and random faults,
  live power bits, paged reads, unmapped codes and ignored writes.
  Assumes the poller model drives the command port at the falling edge.
*/
`default_nettype none

module fault_status_summary_regs_tb
  import fault_status_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin mismatches++; $display("BAD %s exp %h got %h", nm, ex, got); end end

  logic                      clk_sys;
  logic                      sys_rst;
  out_faults_t [NUM_OUT-1:0] flt;
  out_faults_t [NUM_OUT-1:0] sf;
  out_faults_t               u;
  logic        [NUM_OUT-1:0] on_lvl;
  logic        [NUM_OUT-1:0] pg_lvl;
  glob_faults_t              glob;
  glob_faults_t              sg;
  cml_evt_t                  comm_mem_logic_flag;
  cml_evt_t                  sc;
  logic                      clear_faults;
  logic                      rd_req;
  logic                      wr_req;
  logic                      page_sel;
  logic        [7:0]         cmd_code;
  logic                      rd_valid_q;
  logic                      rd_hit_q;
  logic        [15:0]        rd_data_q;
  logic        [16:0]        exp_q[$];
  logic        [16:0]        e;
  logic        [FLAG_W-1:0]  v;
  logic        [31:0]        r;
  int                        mismatches;
  int                        checked;

  // Bank and host model
  fault_status_regs i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .out_flt_pin(flt),
    .out_on_pin(on_lvl), .pgood_pin(pg_lvl), .glob_flt_pin(glob), .cml_evt(comm_mem_logic_flag),
    .clear_faults(clear_faults), .page_sel(page_sel), .rd_req(rd_req), .wr_req(wr_req),
    .cmd_code(cmd_code), .rd_valid_q(rd_valid_q), .rd_hit_q(rd_hit_q),
    .rd_data_q(rd_data_q));
  status_poller i_host (.clk_sys(clk_sys), .rd_req(rd_req), .wr_req(wr_req),
    .cmd_code(cmd_code), .page_sel(page_sel));

  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // Expected read data from the sticky model and live power levels
  function automatic logic [15:0] exp_of(input logic [7:0] code, input logic p);
    logic [7:0] b;
    u = sf[0] | sf[1];
    b = {1'b0, ~&on_lvl, u.ov, u.oc, sg.in_uv, sg.ot | sg.otw | sg.ut, |sc,
         sg.in_ov | sg.in_oc | sg.otp_full | u.uv | u.vmax | u.oc_uv | u.share};
    case (code)
      8'h78: return {8'h00, b};
      // word high byte, low byte equal to summary
      8'h79: return {u.ov | u.uv | u.vmax, u.oc | u.oc_uv | u.share,
                     sg.in_ov | sg.in_uv | sg.in_oc, sg.otp_full, ~&pg_lvl, 3'h0, b};
      8'h7a: return {8'h00, sf[p].ov, 2'b00, sf[p].uv, sf[p].vmax, 3'b000};
      8'h7b: return {8'h00, sf[p].oc, sf[p].oc_uv, 2'b00, sf[p].share, 3'b000};
      default: return 16'h0000;
    endcase
  endfunction

  // Note one read, then issue it
  task automatic rd(input logic [7:0] code, input logic p);
    exp_q.push_back({(code >= 8'h78 && code <= 8'h7b), exp_of(code, p)});
    i_host.issue(1'b0, code, p);
  endtask

  // summaries first, then the detail bytes of one page
  task automatic poll(input logic p);
    exp_q.push_back({1'b1, exp_of(8'h78, p)});
    exp_q.push_back({1'b1, exp_of(8'h79, p)});
    exp_q.push_back({1'b1, exp_of(8'h7a, p)});
    exp_q.push_back({1'b1, exp_of(8'h7b, p)});
    i_host.poll(p);
  endtask

  // Bounded wait for all answers
  task automatic wait_drain();
    for (int i = 0; i < 20 && exp_q.size() != 0; i++) @(negedge clk_sys);
    if (exp_q.size() != 0) begin
      mismatches++;
      $display("BAD answers exp 0 got %0d", exp_q.size());
      tally_and_finish();
    end
  endtask

  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Answer watcher: each valid pulse takes the oldest note
  always @(negedge clk_sys) begin
    if (rd_valid_q === 1'b1) begin
      if (exp_q.size() == 0) begin
        mismatches++;
        $display("BAD rd_valid_q exp 0 got 1");
      end else begin
        e = exp_q.pop_front();
        `CHK("rd_hit_q", e[16], rd_hit_q)
        `CHK("rd_data_q", e[15:0], rd_data_q)
      end
    end
  end

  // Main sequence
  initial begin
    mismatches = 0;
    checked = 0;
    sys_rst = 1'b1;
    clear_faults = 1'b0;
    flt = '0;
    glob = '0;
    comm_mem_logic_flag = '0;
    on_lvl = 2'b11;
    pg_lvl = 2'b11;
    {sc, sg, sf} = '0;
    r = $urandom(32'h2264);
    repeat (10) @(negedge clk_sys);
    `CHK("reset rd_valid_q", 1'b0, rd_valid_q)
    `CHK("reset rd_data_q", 16'h0000, rd_data_q)
    sys_rst = 1'b0;
    for (int k = 0; k < 40; k++) begin
      r = $urandom;
      v = r[FLAG_W-1:0];
      if (k < FLAG_W) v = FLAG_W'(1) << k;
      r = $urandom;
      on_lvl = r[1:0];
      pg_lvl = r[3:2];
      repeat (4) @(negedge clk_sys);
      clear_faults = 1'b1;
      {sc, sg, sf} = '0;
      @(negedge clk_sys);
      clear_faults = 1'b0;
      {comm_mem_logic_flag, glob, flt} = v;
      {sc, sg, sf} = v;
      @(negedge clk_sys);
      comm_mem_logic_flag = '0;
      repeat (4) @(negedge clk_sys);
      // Pins drop; flags must stay until cleared
      glob = '0;
      flt = '0;
      repeat (4) @(negedge clk_sys);
      poll(r[4]);
      poll(~r[4]);
      rd(8'h7c, r[4]);
      rd(8'h77, r[4]);
      i_host.idle();
      wait_drain();
      // a write gives no answer and changes nothing
      i_host.issue(1'b1, 8'h79, r[5]);
      i_host.issue(1'b1, 8'h7a, r[5]);
      i_host.idle();
      repeat (3) @(negedge clk_sys);
      rd(8'h79, r[5]);
      rd(8'h7a, r[5]);
      i_host.idle();
      wait_drain();
    end
    tally_and_finish();
  end

  // Watchdog
  initial begin
    repeat (100000) @(posedge clk_sys);
    mismatches++;
    $display("BAD watchdog exp done got timeout");
    tally_and_finish();
  end

`undef CHK
endmodule

`default_nettype wire
